// ### hw/rtcc_pkg.sv
// Purpose: Shared constants and types for the always-on calendar clock
// Assumes: 32.768 kHz oscillator sampled by a 100 MHz system clock
// Notes: All time fields are BCD, one decimal digit per nibble
package rtcc_pkg;

    // Slow clock
    localparam int TICK_HZ = 32768;
    localparam logic [15:0] TICK_LAST = 16'h7fff;
    localparam int MS_SHIFT = 15;
    localparam int MS_W = 10;
    localparam logic [9:0] MS_PER_S = 10'h3e8;
    localparam int SYS_HZ = 100000000;
    localparam int SYS_PER_TICK = SYS_HZ / TICK_HZ;
    localparam logic [1:0] WR_SLOW_CYCLES = 2'h2;

    // Calendar field positions inside the time vector
    localparam int F_SEC = 0;
    localparam int F_MIN = 1;
    localparam int F_HOUR = 2;
    localparam int F_DATE = 3;
    localparam int F_MONTH = 4;
    localparam int F_YEAR = 5;
    localparam int NFIELD = 6;

    // BCD limits
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] BCD_SEC_MAX = 8'h59;
    localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
    localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
    localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
    localparam logic [7:0] BCD_FEB = 8'h02;
    localparam logic [7:0] BCD_APR = 8'h04;
    localparam logic [7:0] BCD_JUN = 8'h06;
    localparam logic [7:0] BCD_SEP = 8'h09;
    localparam logic [7:0] BCD_NOV = 8'h11;
    localparam logic [7:0] BCD_D28 = 8'h28;
    localparam logic [7:0] BCD_D29 = 8'h29;
    localparam logic [7:0] BCD_D30 = 8'h30;
    localparam logic [7:0] BCD_D31 = 8'h31;
    localparam logic [2:0] WDAY_MIN = 3'h1;
    localparam logic [2:0] WDAY_MAX = 3'h7;

    // Control bit positions
    localparam int CTL_AL_EN = 0;
    localparam int CTL_PER_EN = 1;
    localparam int CTL_WOUT_EN = 2;
    localparam int CTL_WIN_EN = 3;
    localparam int CTL_W = 4;

    // Register selects for the write and read ports
    typedef enum logic [4:0] {
        RTCC_R_SEC, RTCC_R_MIN, RTCC_R_HOUR, RTCC_R_DATE, RTCC_R_MONTH, RTCC_R_YEAR,
        RTCC_R_WDAY, RTCC_R_AL_SEC, RTCC_R_AL_MIN, RTCC_R_AL_HOUR, RTCC_R_AL_WDAY,
        RTCC_R_ALCFG, RTCC_R_CTL, RTCC_R_DRIFT, RTCC_R_MS, RTCC_R_FLAGS,
        RTCC_R_SCR0, RTCC_R_SCR1, RTCC_R_SCR2, RTCC_R_SCR3
    } rtcc_reg_t;

    typedef enum logic [2:0] {
        RTCC_AL_SEC, RTCC_AL_MIN, RTCC_AL_HOUR, RTCC_AL_DAY, RTCC_AL_WEEK
    } rtcc_al_mode_t;

    typedef enum logic [2:0] {
        RTCC_PER_MS, RTCC_PER_SEC, RTCC_PER_MIN, RTCC_PER_HOUR, RTCC_PER_DAY
    } rtcc_per_t;

    typedef struct packed {
        logic [2:0] wday;
        logic [NFIELD-1:0][7:0] f;
    } rtcc_time_t;

    typedef struct packed {
        logic periodic;
        logic alarm;
    } rtcc_flags_t;

    typedef struct packed {
        logic en;
        rtcc_reg_t sel;
        logic [15:0] data;
    } rtcc_wr_t;

endpackage

// ### hw/rtcc_bcd_step.sv
// Purpose: One BCD calendar field advanced by one unit
// Assumes: Value is two BCD digits
// Notes: Any value at or above the limit wraps, so bad writes heal
`timescale 1ns/100ps
module rtcc_bcd_step (
    // Field
    input wire logic [7:0] i_val,
    input wire logic [7:0] i_lo,
    input wire logic [7:0] i_hi,
    // Result
    output logic [7:0] o_nxt,
    output logic o_wrap
);
    import rtcc_pkg::*;

    assign o_wrap = (i_val >= i_hi);
    assign o_nxt = o_wrap ? i_lo :
                   (i_val[3:0] >= BCD_DIGIT_MAX) ? {i_val[7:4] + 4'h1, 4'h0} : i_val + 8'h01;
endmodule

// ### hw/rtcc_core.sv
// Purpose: Always-on calendar clock with alarm, periodic event and wake pin
// Assumes: i_rstn is the always-on supply power-on reset; i_osc_32k is the crystal clock
// Notes: The slow clock is sampled, not used as a clock; writes land on slow edges
// Overview of operation
// - Time, alarm and trim settings survive core power loss; control bits do not
// - Alarm, periodic or wake input request wakeup
// - Alarm or periodic event drives wake pin
// - Hundred year calendar ending at 2099
// - 24-hour time, weekday, date, leap Februaries
// - Time and alarm fields held in BCD
// - Alarm granularity second to week
// - Alarm at exact time of day
// - Periodic event: ms, second, minute, hour, day
// - All events merged on one interrupt
// - Counts 32.768 kHz with drift trim
// - Writes take effect two slow edges later
// - Oscillator off: writes ignored
// - Own power-on reset clears everything
// - Device reset or core power-good low clears control bits and any pending write
// - Scratch words survive core resets
`timescale 1ns/100ps
module rtcc_core (
    // Clock and always-on reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Oscillator
    input wire logic i_osc_32k,
    input wire logic i_osc_en,
    // Core domain status pins
    input wire logic i_dev_rstn,
    input wire logic i_core_pwr_good,
    // Register ports
    input wire rtcc_pkg::rtcc_wr_t i_wr,
    input wire rtcc_pkg::rtcc_reg_t i_rd_sel,
    input wire rtcc_pkg::rtcc_flags_t i_flag_clr,
    output rtcc_pkg::rtcc_flags_t o_flags,
    output logic [15:0] o_rd_data,
    output logic o_wr_busy,
    // Time
    output rtcc_pkg::rtcc_time_t o_time,
    output logic [9:0] o_ms,
    // Events
    output logic o_irq,
    output logic o_wake_req,
    // Open-drain wake pin, low is asserted
    input wire logic i_wake_pin,
    output logic o_wake_pin,
    output logic o_wake_pin_oe
);
    import rtcc_pkg::*;

    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_d;
        logic wk_s1;
        logic wk_s2;
        logic keep_s1;
        logic keep_s2;
        logic [15:0] tcnt;
        logic [9:0] ms;
        rtcc_time_t tm;
        rtcc_time_t al;
        rtcc_al_mode_t al_mode;
        rtcc_per_t per_sel;
        logic [CTL_W-1:0] ctl;
        logic [7:0] drift;
        logic [3:0][15:0] scr;
        rtcc_wr_t pend;
        logic [1:0] wr_cnt;
        rtcc_flags_t fl;
        logic [15:0] rd;
    } rtcc_st_t;

    rtcc_st_t st_ff;
    rtcc_st_t nxt_st;

    logic [NFIELD-1:0][7:0] cur;
    logic [NFIELD-1:0][7:0] lo;
    logic [NFIELD-1:0][7:0] hi;
    logic [NFIELD-1:0][7:0] step;
    logic [NFIELD-1:0] wrap;
    logic [NFIELD:0] carry;
    logic leap;
    logic [7:0] dim;
    logic tick;
    logic sec_tick;
    logic [15:0] tlim;
    logic [25:0] ms_prod;
    logic [9:0] ms_new;

    // Year 00 is 2000, so every fourth year is leap up to 2099
    assign leap = st_ff.tm.f[F_YEAR][4] ?
                  (st_ff.tm.f[F_YEAR][3:0] == 4'h2 || st_ff.tm.f[F_YEAR][3:0] == 4'h6) :
                  (st_ff.tm.f[F_YEAR][3:0] == 4'h0 || st_ff.tm.f[F_YEAR][3:0] == 4'h4 ||
                   st_ff.tm.f[F_YEAR][3:0] == 4'h8);
    assign dim = (st_ff.tm.f[F_MONTH] == BCD_FEB) ? (leap ? BCD_D29 : BCD_D28) :
                 (st_ff.tm.f[F_MONTH] == BCD_APR || st_ff.tm.f[F_MONTH] == BCD_JUN ||
                  st_ff.tm.f[F_MONTH] == BCD_SEP || st_ff.tm.f[F_MONTH] == BCD_NOV) ?
                 BCD_D30 : BCD_D31;

    assign cur = st_ff.tm.f;
    assign lo = {BCD_ZERO, BCD_ONE, BCD_ONE, BCD_ZERO, BCD_ZERO, BCD_ZERO};
    assign hi = {BCD_YEAR_MAX, BCD_MONTH_MAX, dim, BCD_HOUR_MAX, BCD_SEC_MAX, BCD_SEC_MAX};

    // Slow edge qualified by the enable; a stopped oscillator freezes time
    assign tick = st_ff.osc_s2 & ~st_ff.osc_d & i_osc_en;
    assign tlim = TICK_LAST + {{8{st_ff.drift[7]}}, st_ff.drift};
    assign sec_tick = tick & (st_ff.tcnt >= tlim);
    assign carry[0] = sec_tick;

    // Ripple of BCD fields, seconds up to years
    genvar gi;
    generate
        for (gi = 0; gi < NFIELD; gi++) begin : g_field
            rtcc_bcd_step u_step (
                .i_val(cur[gi]),
                .i_lo(lo[gi]),
                .i_hi(hi[gi]),
                .o_nxt(step[gi]),
                .o_wrap(wrap[gi])
            );
            assign carry[gi+1] = carry[gi] & wrap[gi];
        end
    endgenerate

    always_comb begin
        logic [NFIELD-1:0][7:0] nt;
        logic [2:0] nwd;
        logic al_hit;
        logic per_hit;
        logic ms_chg;
        nt = cur;
        nwd = st_ff.tm.wday;
        al_hit = 1'b0;
        per_hit = 1'b0;
        ms_chg = 1'b0;
        nxt_st = st_ff;

        // Pins from other domains pass two flops first
        nxt_st.osc_s1 = i_osc_32k;
        nxt_st.osc_s2 = st_ff.osc_s1;
        nxt_st.osc_d = st_ff.osc_s2;
        nxt_st.wk_s1 = i_wake_pin;
        nxt_st.wk_s2 = st_ff.wk_s1;
        nxt_st.keep_s1 = i_dev_rstn & i_core_pwr_good;
        nxt_st.keep_s2 = st_ff.keep_s1;

        // Sub-second count and derived milliseconds
        if (tick) begin
            nxt_st.tcnt = sec_tick ? 16'h0000 : st_ff.tcnt + 16'h0001;
        end
        ms_prod = 26'(nxt_st.tcnt) * 26'(MS_PER_S);
        ms_new = ms_prod[MS_SHIFT +: MS_W];
        // Positive trim lengthens the second; hold the last millisecond rather than show 1000
        if (ms_new >= MS_PER_S) begin
            ms_new = MS_PER_S - 10'h001;
        end
        ms_chg = tick & (ms_new != st_ff.ms);
        nxt_st.ms = ms_new;

        for (int i = 0; i < NFIELD; i++) begin
            if (carry[i]) begin
                nt[i] = step[i];
            end
        end
        if (carry[F_DATE]) begin
            nwd = (st_ff.tm.wday >= WDAY_MAX) ? WDAY_MIN : st_ff.tm.wday + 3'h1;
        end
        nxt_st.tm.f = nt;
        nxt_st.tm.wday = nwd;

        // Alarm checked against the time just reached
        if (sec_tick) begin
            unique case (st_ff.al_mode)
                RTCC_AL_SEC: al_hit = 1'b1;
                RTCC_AL_MIN: al_hit = nt[F_SEC] == st_ff.al.f[F_SEC];
                RTCC_AL_HOUR: al_hit = nt[F_SEC] == st_ff.al.f[F_SEC] &&
                                       nt[F_MIN] == st_ff.al.f[F_MIN];
                RTCC_AL_DAY: al_hit = nt[F_SEC] == st_ff.al.f[F_SEC] &&
                                      nt[F_MIN] == st_ff.al.f[F_MIN] &&
                                      nt[F_HOUR] == st_ff.al.f[F_HOUR];
                RTCC_AL_WEEK: al_hit = nt[F_SEC] == st_ff.al.f[F_SEC] &&
                                       nt[F_MIN] == st_ff.al.f[F_MIN] &&
                                       nt[F_HOUR] == st_ff.al.f[F_HOUR] &&
                                       nwd == st_ff.al.wday;
                default: al_hit = 1'b0;
            endcase
        end

        unique case (st_ff.per_sel)
            RTCC_PER_MS: per_hit = ms_chg;
            RTCC_PER_SEC: per_hit = carry[F_SEC];
            RTCC_PER_MIN: per_hit = carry[F_MIN];
            RTCC_PER_HOUR: per_hit = carry[F_HOUR];
            RTCC_PER_DAY: per_hit = carry[F_DATE];
            default: per_hit = 1'b0;
        endcase

        // Set beats clear so no event is lost
        nxt_st.fl.alarm = (st_ff.fl.alarm & ~i_flag_clr.alarm) | al_hit;
        nxt_st.fl.periodic = (st_ff.fl.periodic & ~i_flag_clr.periodic) | per_hit;

        // Write capture; one in flight, later ones dropped while busy
        if (i_wr.en && i_osc_en && !st_ff.pend.en) begin
            nxt_st.pend = i_wr;
            nxt_st.wr_cnt = 2'h0;
        end
        if (st_ff.pend.en && tick) begin
            nxt_st.wr_cnt = st_ff.wr_cnt + 2'h1;
            if (st_ff.wr_cnt + 2'h1 >= WR_SLOW_CYCLES) begin
                nxt_st.pend.en = 1'b0;
                unique case (st_ff.pend.sel)
                    RTCC_R_SEC: begin
                        nxt_st.tm.f[F_SEC] = st_ff.pend.data[7:0];
                        nxt_st.tcnt = 16'h0000;
                        nxt_st.ms = '0;
                    end
                    RTCC_R_MIN: nxt_st.tm.f[F_MIN] = st_ff.pend.data[7:0];
                    RTCC_R_HOUR: nxt_st.tm.f[F_HOUR] = st_ff.pend.data[7:0];
                    RTCC_R_DATE: nxt_st.tm.f[F_DATE] = st_ff.pend.data[7:0];
                    RTCC_R_MONTH: nxt_st.tm.f[F_MONTH] = st_ff.pend.data[7:0];
                    RTCC_R_YEAR: nxt_st.tm.f[F_YEAR] = st_ff.pend.data[7:0];
                    RTCC_R_WDAY: nxt_st.tm.wday = st_ff.pend.data[2:0];
                    RTCC_R_AL_SEC: nxt_st.al.f[F_SEC] = st_ff.pend.data[7:0];
                    RTCC_R_AL_MIN: nxt_st.al.f[F_MIN] = st_ff.pend.data[7:0];
                    RTCC_R_AL_HOUR: nxt_st.al.f[F_HOUR] = st_ff.pend.data[7:0];
                    RTCC_R_AL_WDAY: nxt_st.al.wday = st_ff.pend.data[2:0];
                    RTCC_R_ALCFG: begin
                        nxt_st.al_mode = rtcc_al_mode_t'(st_ff.pend.data[2:0]);
                        nxt_st.per_sel = rtcc_per_t'(st_ff.pend.data[6:4]);
                    end
                    RTCC_R_CTL: nxt_st.ctl = st_ff.pend.data[CTL_W-1:0];
                    RTCC_R_DRIFT: nxt_st.drift = st_ff.pend.data[7:0];
                    RTCC_R_SCR0: nxt_st.scr[0] = st_ff.pend.data;
                    RTCC_R_SCR1: nxt_st.scr[1] = st_ff.pend.data;
                    RTCC_R_SCR2: nxt_st.scr[2] = st_ff.pend.data;
                    RTCC_R_SCR3: nxt_st.scr[3] = st_ff.pend.data;
                    default: nxt_st.pend.en = 1'b0;
                endcase
            end
        end

        // Only control and pending update follow the core domain
        if (!st_ff.keep_s2) begin
            nxt_st.ctl = '0;
            nxt_st.pend.en = 1'b0;
        end

        // Read view, registered
        unique case (i_rd_sel)
            RTCC_R_SEC: nxt_st.rd = {8'h00, st_ff.tm.f[F_SEC]};
            RTCC_R_MIN: nxt_st.rd = {8'h00, st_ff.tm.f[F_MIN]};
            RTCC_R_HOUR: nxt_st.rd = {8'h00, st_ff.tm.f[F_HOUR]};
            RTCC_R_DATE: nxt_st.rd = {8'h00, st_ff.tm.f[F_DATE]};
            RTCC_R_MONTH: nxt_st.rd = {8'h00, st_ff.tm.f[F_MONTH]};
            RTCC_R_YEAR: nxt_st.rd = {8'h00, st_ff.tm.f[F_YEAR]};
            RTCC_R_WDAY: nxt_st.rd = {13'h0, st_ff.tm.wday};
            RTCC_R_AL_SEC: nxt_st.rd = {8'h00, st_ff.al.f[F_SEC]};
            RTCC_R_AL_MIN: nxt_st.rd = {8'h00, st_ff.al.f[F_MIN]};
            RTCC_R_AL_HOUR: nxt_st.rd = {8'h00, st_ff.al.f[F_HOUR]};
            RTCC_R_AL_WDAY: nxt_st.rd = {13'h0, st_ff.al.wday};
            RTCC_R_ALCFG: nxt_st.rd = {9'h000, st_ff.per_sel, 1'b0, st_ff.al_mode};
            RTCC_R_CTL: nxt_st.rd = {12'h000, st_ff.ctl};
            RTCC_R_DRIFT: nxt_st.rd = {8'h00, st_ff.drift};
            RTCC_R_MS: nxt_st.rd = {6'h00, st_ff.ms};
            RTCC_R_FLAGS: nxt_st.rd = {14'h0, st_ff.fl};
            RTCC_R_SCR0: nxt_st.rd = st_ff.scr[0];
            RTCC_R_SCR1: nxt_st.rd = st_ff.scr[1];
            RTCC_R_SCR2: nxt_st.rd = st_ff.scr[2];
            RTCC_R_SCR3: nxt_st.rd = st_ff.scr[3];
            default: nxt_st.rd = 16'h0000;
        endcase
    end

    // Only the always-on power-on reset clears all of this state; core resets clear control and pending write
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st_ff <= '0;
            st_ff.tm.f[F_DATE] <= BCD_ONE;
            st_ff.tm.f[F_MONTH] <= BCD_ONE;
            st_ff.tm.wday <= WDAY_MIN;
            st_ff.al.wday <= WDAY_MIN;
            // Core presumed up and wake pin idle high, so the first write survives release
            st_ff.keep_s1 <= 1'b1;
            st_ff.keep_s2 <= 1'b1;
            st_ff.wk_s1 <= 1'b1;
            st_ff.wk_s2 <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Busy also stalls the caller, which holds margins
    assign o_wr_busy = st_ff.pend.en;
    assign o_flags = st_ff.fl;
    assign o_rd_data = st_ff.rd;
    assign o_time = st_ff.tm;
    assign o_ms = st_ff.ms;
    assign o_irq = (st_ff.fl.alarm & st_ff.ctl[CTL_AL_EN]) |
                   (st_ff.fl.periodic & st_ff.ctl[CTL_PER_EN]);
    assign o_wake_pin = 1'b0;
    assign o_wake_pin_oe = o_irq & st_ff.ctl[CTL_WOUT_EN];
    assign o_wake_req = o_irq | (st_ff.ctl[CTL_WIN_EN] & ~st_ff.wk_s2);
endmodule

// ### dv/rtcc_core_props.sv
// Purpose: Port-level checks for the always-on calendar clock
// Assumes: Bench oscillator runs at a quarter of the system clock
// Notes: Write completion bound holds only for the fast bench oscillator
`timescale 1ns/100ps
module rtcc_core_props (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Watched inputs
    input wire logic i_osc_en,
    input wire rtcc_pkg::rtcc_wr_t i_wr,
    input wire rtcc_pkg::rtcc_flags_t i_flag_clr,
    // Watched outputs
    input wire rtcc_pkg::rtcc_flags_t o_flags,
    input wire logic o_wr_busy,
    input wire rtcc_pkg::rtcc_time_t o_time,
    input wire logic [9:0] o_ms,
    input wire logic o_irq,
    input wire logic o_wake_req,
    input wire logic o_wake_pin,
    input wire logic o_wake_pin_oe
);
    import rtcc_pkg::*;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    property p_wr_take;
        i_wr.en && i_osc_en && !o_wr_busy |=> o_wr_busy;
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("write not taken");
    // Two slow edges can never land in fewer than four system cycles
    property p_wr_hold;
        $rose(o_wr_busy) |-> o_wr_busy [*4];
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write applied too early");
    property p_wr_done;
        $rose(o_wr_busy) |-> ##[1:200] !o_wr_busy;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("write never applied");
    property p_osc_refuse;
        !i_osc_en && !o_wr_busy |=> !o_wr_busy;
    endproperty
    a_osc_refuse: assert property (p_osc_refuse) else $error("write taken with oscillator off");
    property p_osc_freeze;
        !i_osc_en [*4] |-> $stable(o_time) && $stable(o_ms);
    endproperty
    a_osc_freeze: assert property (p_osc_freeze) else $error("time moved with oscillator off");
    property p_sticky;
        o_flags.periodic && !i_flag_clr.periodic |=> o_flags.periodic;
    endproperty
    a_sticky: assert property (p_sticky) else $error("periodic flag dropped");
    property p_sticky_al;
        o_flags.alarm && !i_flag_clr.alarm |=> o_flags.alarm;
    endproperty
    a_sticky_al: assert property (p_sticky_al) else $error("alarm flag dropped");
    property p_irq_src;
        o_irq |-> o_flags.alarm || o_flags.periodic;
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("interrupt without flag");
    property p_wake_oe;
        o_wake_pin_oe |-> o_irq && !o_wake_pin;
    endproperty
    a_wake_oe: assert property (p_wake_oe) else $error("wake pin driven without event");
    property p_wake_req;
        o_irq |-> o_wake_req;
    endproperty
    a_wake_req: assert property (p_wake_req) else $error("event without wake request");
    property p_bcd;
        o_time.f[F_SEC] <= BCD_SEC_MAX && o_time.f[F_MIN] <= BCD_SEC_MAX && o_time.f[F_HOUR] <= BCD_HOUR_MAX
            && o_time.f[F_SEC][3:0] <= 4'h9 && o_time.f[F_MIN][3:0] <= 4'h9 && o_time.f[F_DATE][3:0] <= 4'h9;
    endproperty
    a_bcd: assert property (p_bcd) else $error("time field not BCD");
    property p_ms;
        o_ms < MS_PER_S;
    endproperty
    a_ms: assert property (p_ms) else $error("millisecond count out of range");
    c_per: cover property ($rose(o_flags.periodic));
    c_wake: cover property ($rose(o_wake_pin_oe));
    c_busy: cover property ($rose(o_wr_busy));
endmodule

bind rtcc_core rtcc_core_props u_rtcc_core_props (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_osc_en(i_osc_en), .i_wr(i_wr), .i_flag_clr(i_flag_clr),
    .o_flags(o_flags), .o_wr_busy(o_wr_busy), .o_time(o_time), .o_ms(o_ms), .o_irq(o_irq),
    .o_wake_req(o_wake_req), .o_wake_pin(o_wake_pin), .o_wake_pin_oe(o_wake_pin_oe)
);

// ### dv/testbench.sv
// Purpose: Self-checking bench for the always-on calendar clock
// Assumes: Oscillator toggles every 2 system cycles, four times slower
// Notes: A full second is too long here, so rollovers rest on the checker
`timescale 1ns/100ps
module testbench;
    import rtcc_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic i_osc_32k = 1'b0;
    logic osc_div = 1'b0;
    logic i_osc_en = 1'b1;
    logic i_dev_rstn = 1'b1;
    logic i_core_pwr_good = 1'b1;
    logic ext_wake_n = 1'b1;
    rtcc_wr_t i_wr = '0;
    rtcc_reg_t i_rd_sel = RTCC_R_SEC;
    rtcc_flags_t i_flag_clr = '0;
    rtcc_flags_t o_flags;
    rtcc_time_t o_time;
    logic [15:0] o_rd_data;
    logic [9:0] o_ms;
    logic o_wr_busy, o_irq, o_wake_req, o_wake_pin, o_wake_pin_oe;
    wire logic i_wake_pin;
    logic rd_mark = 1'b0;
    logic rd_d1 = 1'b0;
    logic [15:0] exp_q[$];
    string name_q[$];
    logic [15:0] rnd;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    rtcc_reg_t fsel[9] = '{RTCC_R_YEAR, RTCC_R_MONTH, RTCC_R_HOUR, RTCC_R_MIN, RTCC_R_DATE, RTCC_R_WDAY,
        RTCC_R_DRIFT, RTCC_R_AL_MIN, RTCC_R_SEC};
    logic [7:0] fval[9] = '{8'h99, 8'h12, 8'h23, 8'h59, 8'h31, 8'h07, 8'h81, 8'h45, 8'h30};

    // Open drain wire with pull-up: low if anyone pulls it
    assign i_wake_pin = ext_wake_n & ~(o_wake_pin_oe & ~o_wake_pin);

    rtcc_core u_rtcc_core (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_osc_32k(i_osc_32k), .i_osc_en(i_osc_en),
        .i_dev_rstn(i_dev_rstn), .i_core_pwr_good(i_core_pwr_good), .i_wr(i_wr), .i_rd_sel(i_rd_sel),
        .i_flag_clr(i_flag_clr), .o_flags(o_flags), .o_rd_data(o_rd_data), .o_wr_busy(o_wr_busy),
        .o_time(o_time), .o_ms(o_ms), .o_irq(o_irq), .o_wake_req(o_wake_req), .i_wake_pin(i_wake_pin),
        .o_wake_pin(o_wake_pin), .o_wake_pin_oe(o_wake_pin_oe)
    );

    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // Crystal stops when disabled, as a real one would
    always @(posedge i_clk_sys) begin
        if (i_osc_en) begin
            osc_div <= ~osc_div;
            if (osc_div) i_osc_32k <= ~i_osc_32k;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            errors++;
            report_and_stop();
        end
    end

    // Read results appear one cycle after the select is taken
    always @(posedge i_clk_sys) begin
        rd_d1 <= rd_mark;
        if (rd_d1 && exp_q.size() > 0) check(name_q.pop_front(), o_rd_data, exp_q.pop_front());
    end

    task automatic tick(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic rd(input rtcc_reg_t sel, input logic [15:0] exp, input string what);
        @(posedge i_clk_sys);
        i_rd_sel <= sel;
        rd_mark <= 1'b1;
        exp_q.push_back(exp);
        name_q.push_back(what);
        @(posedge i_clk_sys);
        rd_mark <= 1'b0;
    endtask

    task automatic wr_pulse(input rtcc_reg_t sel, input logic [15:0] data);
        @(posedge i_clk_sys);
        i_wr <= '{en: 1'b1, sel: sel, data: data};
        @(posedge i_clk_sys);
        i_wr.en <= 1'b0;
    endtask

    task automatic wr_wait();
        int k;
        tick(1);
        for (k = 0; k < 200 && o_wr_busy !== 1'b0; k++) tick(1);
        check("busy", {15'h0, o_wr_busy}, 16'h0000);
    endtask

    task automatic wr(input rtcc_reg_t sel, input logic [15:0] data);
        wr_pulse(sel, data);
        wr_wait();
    endtask

    task automatic clr();
        @(posedge i_clk_sys);
        i_flag_clr <= '{periodic: 1'b1, alarm: 1'b1};
        @(posedge i_clk_sys);
        i_flag_clr <= '0;
        tick(1);
    endtask

    task automatic wait_per(output int cnt);
        for (cnt = 0; cnt < 600 && o_flags.periodic !== 1'b1; cnt++) tick(1);
    endtask

    initial begin
        rnd = 16'($urandom(32'hfea4e33f));
        rnd = 16'($urandom());
        repeat (6) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        rd(RTCC_R_SEC, 16'h0000, "sec");
        rd(RTCC_R_DATE, 16'h0001, "date");
        rd(RTCC_R_MONTH, 16'h0001, "month");
        rd(RTCC_R_WDAY, 16'h0001, "wday");
        rd(RTCC_R_AL_WDAY, 16'h0001, "alarm wday");
        // Second write lands while the first is pending and must vanish
        wr_pulse(RTCC_R_SCR0, rnd);
        wr_pulse(RTCC_R_SCR1, ~rnd);
        rd(RTCC_R_SCR0, 16'h0000, "scr0 early");
        wr_wait();
        rd(RTCC_R_SCR0, rnd, "scr0");
        rd(RTCC_R_SCR1, 16'h0000, "scr1 dropped");
        foreach (fsel[i]) begin
            wr(fsel[i], {8'h00, fval[i]});
            rd(fsel[i], {8'h00, fval[i]}, "field");
        end
        tick(1);
        check("year", {8'h00, o_time.f[F_YEAR]}, 16'h0099);
        check("ms after sec write", {6'h00, o_ms}, 16'h0000);
        @(posedge i_clk_sys);
        i_osc_en <= 1'b0;
        tick(4);
        wr_pulse(RTCC_R_SCR2, rnd);
        tick(4);
        check("busy osc off", {15'h0, o_wr_busy}, 16'h0000);
        rd(RTCC_R_SCR2, 16'h0000, "scr2 osc off");
        i_osc_en <= 1'b1;
        wr(RTCC_R_ALCFG, 16'h0000);
        wr(RTCC_R_CTL, 16'h0006);
        clr();
        wait_per(n);
        clr();
        check("flag cleared", {14'h0, o_flags}, 16'h0000);
        wait_per(n);
        check("ms period", 16'(n >= 100 && n <= 140), 16'h0001);
        check("irq", {15'h0, o_irq}, 16'h0001);
        check("wake oe", {15'h0, o_wake_pin_oe}, 16'h0001);
        check("wake wire", {15'h0, i_wake_pin}, 16'h0000);
        check("wake req", {15'h0, o_wake_req}, 16'h0001);
        wr(RTCC_R_CTL, 16'h0000);
        clr();
        wait_per(n);
        tick(1);
        check("masked irq", {14'h0, o_irq, o_wake_pin_oe}, 16'h0000);
        check("masked req", {15'h0, o_wake_req}, 16'h0000);
        wr(RTCC_R_CTL, 16'h0008);
        @(posedge i_clk_sys);
        ext_wake_n <= 1'b0;
        tick(4);
        check("wake in", {15'h0, o_wake_req}, 16'h0001);
        @(posedge i_clk_sys);
        ext_wake_n <= 1'b1;
        tick(4);
        check("wake in off", {15'h0, o_wake_req}, 16'h0000);
        wr(RTCC_R_CTL, 16'h0002);
        tick(1);
        check("irq sticky", {15'h0, o_irq}, 16'h0001);
        @(posedge i_clk_sys);
        i_dev_rstn <= 1'b0;
        @(posedge i_clk_sys);
        i_dev_rstn <= 1'b1;
        i_core_pwr_good <= 1'b0;
        @(posedge i_clk_sys);
        i_core_pwr_good <= 1'b1;
        tick(4);
        check("ctl lost", {15'h0, o_irq}, 16'h0000);
        rd(RTCC_R_SCR0, rnd, "scr0 kept");
        rd(RTCC_R_YEAR, 16'h0099, "year kept");
        tick(3);
        report_and_stop();
    end
endmodule
